/* File: rtl/mpd_top.sv */
//
// Functional notes
// - Resistance code: 3-bit exponent over 4-bit mantissa
// - Resistance magnitude is mantissa shifted by exponent
// - One resistance unit is 9.67 milliohm
// - All-ones resistance code gives 1920
// - Back-EMF code decodes as mantissa shifted by exponent
// - All-ones back-EMF code gives 1920
// - Back-EMF code one gives magnitude one
// - Resistance code lives in first config register
// - Back-EMF code lives in second config register
`timescale 1ns/100ps
module mpd_top
  import mpd_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [LIN_W-1:0] res_linear,
  output logic [LIN_W-1:0] bemf_linear,
  output logic res_below_min
);

  mpd_req_t req;
  mpd_req_t next_req;
  mpd_cfg_t cfg;
  mpd_cfg_t next_cfg;
  logic [31:0] next_hrdata;
  logic [LIN_W-1:0] next_res_linear;
  logic [LIN_W-1:0] next_bemf_linear;
  logic next_res_below_min;
  logic [LIN_W-1:0] dec_res;
  logic [LIN_W-1:0] dec_bemf;
  logic [CODE_W-1:0] wdata_code;

  assign wdata_code = hwdata[CODE_W-1:0];

  // Both codes share one decoder shape; a loop keeps them identical
  for (genvar i = 0; i < 2; i++) begin : g_dec
    logic [CODE_W-1:0] code_i;
    logic [LIN_W-1:0] lin_i;
    assign code_i = (i == 0) ? cfg.phase_res_code : cfg.bemf_code;
    mpd_code_expand #(
      .EW(EXP_W),
      .MW(MANT_W),
      .OW(LIN_W)
    ) u_expand (
      .code(code_i),
      .linear(lin_i)
    );
    if (i == 0) begin : g_res
      assign dec_res = lin_i;
    end else begin : g_bemf
      assign dec_bemf = lin_i;
    end
  end

  // Bus: zero wait states, so hreadyout only leaves high never
  always_comb begin
    next_req.valid = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'h3);
    next_req.write = hwrite;
    next_req.addr = haddr[7:0];
    next_cfg = cfg;
    if (req.valid && req.write) begin
      unique case (req.addr)
        OFS_MOTOR_CFG_FIRST: next_cfg.phase_res_code = wdata_code;
        OFS_MOTOR_CFG_SECOND: next_cfg.bemf_code = wdata_code;
        default: next_cfg = cfg;
      endcase
    end
  end

  // Code read data is taken from the next values so a read right after a write sees it; magnitudes read the registered outputs
  always_comb begin
    next_hrdata = 32'h0000_0000;
    if (next_req.valid && !next_req.write) begin
      unique case (next_req.addr)
        OFS_MOTOR_CFG_FIRST: next_hrdata = {25'h0, next_cfg.phase_res_code};
        OFS_MOTOR_CFG_SECOND: next_hrdata = {25'h0, next_cfg.bemf_code};
        OFS_RES_LINEAR: next_hrdata = {20'h0, res_below_min, res_linear};
        OFS_BEMF_LINEAR: next_hrdata = {21'h0, bemf_linear};
        OFS_SCALE: next_hrdata = {BEMF_WEIGHT, RES_LSB_UOHM};
        default: next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  // Magnitudes are registered so outputs come from flops; one cycle behind the code
  always_comb begin
    next_res_linear = dec_res;
    next_bemf_linear = dec_bemf;
    // Flags a nonzero decoded magnitude below the supported minimum; zero means unset
    next_res_below_min = (dec_res != 11'h000) && (dec_res < RES_LINEAR_MIN);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req <= '0;
      cfg <= {RST_CODE, RST_CODE};
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      res_linear <= RST_LINEAR;
      bemf_linear <= RST_LINEAR;
      res_below_min <= 1'b0;
    end else begin
      req <= next_req;
      cfg <= next_cfg;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      res_linear <= next_res_linear;
      bemf_linear <= next_bemf_linear;
      res_below_min <= next_res_below_min;
    end
  end

  // Checks
  logic [LIN_W-1:0] ref_res;
  logic [LIN_W-1:0] ref_bemf;
  logic [CODE_W-1:0] res_code_mon;
  logic [CODE_W-1:0] bemf_code_mon;
  assign res_code_mon = cfg.phase_res_code;
  assign bemf_code_mon = cfg.bemf_code;
  assign ref_res = LIN_W'(res_code_mon[EXP_LSB-1:MANT_LSB]) << res_code_mon[CODE_W-1:EXP_LSB];
  assign ref_bemf = LIN_W'(bemf_code_mon[EXP_LSB-1:MANT_LSB]) << bemf_code_mon[CODE_W-1:EXP_LSB];

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_addr_phase(logic [7:0] ofs);
    hsel && hready && htrans == HTRANS_NONSEQ && hwrite && haddr[7:0] == ofs;
  endsequence

  // Read address phase; its data comes out of hrdata at the next edge
  sequence s_rd_phase(logic [7:0] ofs);
    hsel && hready && htrans == HTRANS_NONSEQ && !hwrite && haddr[7:0] == ofs;
  endsequence

  sequence s_wr_first;
    s_addr_phase(OFS_MOTOR_CFG_FIRST) ##1 1'b1;
  endsequence

  sequence s_wr_second;
    s_addr_phase(OFS_MOTOR_CFG_SECOND) ##1 1'b1;
  endsequence

  chk_first_write: assert property (s_wr_first |=> res_code_mon == $past(wdata_code))
    else $error("resistance code not taken from first config write");
  chk_second_write: assert property (s_wr_second |=> bemf_code_mon == $past(wdata_code))
    else $error("back-EMF code not taken from second config write");
  chk_res_decode: assert property (s_wr_first ##1 1'b1 |=> res_linear == $past(ref_res))
    else $error("resistance magnitude does not match code");
  chk_bemf_decode: assert property (1'b1 |=> bemf_linear == $past(ref_bemf))
    else $error("back-EMF magnitude does not match code");
  chk_res_max: assert property (res_code_mon == 7'h7f |=> res_linear == 11'h780)
    else $error("all-ones resistance code did not give 1920");
  chk_bemf_max: assert property (bemf_code_mon == 7'h7f |=> bemf_linear == LINEAR_MAX)
    else $error("all-ones back-EMF code did not give 1920");
  chk_bemf_min: assert property (bemf_code_mon == 7'h01 |=> bemf_linear == 11'h001)
    else $error("back-EMF code one did not give one");
  chk_zero_code: assert property (res_code_mon == 7'h00 |=> res_linear == 11'h000)
    else $error("zero resistance code did not give zero");
  chk_hold_steady: assert property ($stable(res_code_mon) [*2] |-> $stable(res_linear))
    else $error("resistance magnitude moved with code held");
  chk_low_flag: assert property (res_code_mon == 7'h02 |=> res_below_min ##1 1'b1)
    else $error("low resistance flag not raised");
  chk_scale_read: assert property (s_rd_phase(OFS_SCALE) |=>
      hrdata == {BEMF_WEIGHT, RES_LSB_UOHM})
    else $error("scale register does not read the resistance step");
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("slave left OKAY zero-wait response");

  // Readback follows the stored codes and the registered magnitudes
  chk_read_first: assert property (s_rd_phase(OFS_MOTOR_CFG_FIRST) |=>
      hrdata == {25'h0, res_code_mon})
    else $error("first config register does not read back its code");
  chk_read_second: assert property (s_rd_phase(OFS_MOTOR_CFG_SECOND) |=>
      hrdata == {25'h0, bemf_code_mon})
    else $error("second config register does not read back its code");
  chk_read_res: assert property (s_rd_phase(OFS_RES_LINEAR) |=>
      hrdata == {20'h0, $past(res_below_min), $past(res_linear)})
    else $error("resistance magnitude register reads wrong value");
  chk_read_bemf: assert property (s_rd_phase(OFS_BEMF_LINEAR) |=>
      hrdata == {21'h0, $past(bemf_linear)})
    else $error("back-EMF magnitude register reads wrong value");

  // Read data stands for the data phase only, so stale values never linger
  chk_idle_zero: assert property (!(hsel && hready && htrans[1] && !hwrite) |=>
      hrdata == 32'h0000_0000)
    else $error("read data not cleared outside a read data phase");

  // A write to a read-only offset must not leak into either code
  chk_ro_ignored: assert property (s_addr_phase(OFS_BEMF_LINEAR) ##1 1'b1 |=>
      $stable(res_code_mon) && $stable(bemf_code_mon))
    else $error("write to read-only offset changed a code");

  // Decode limits and zero cases
  chk_res_range: assert property (res_linear <= LINEAR_MAX)
    else $error("resistance magnitude above the largest code value");
  chk_bemf_range: assert property (bemf_linear <= LINEAR_MAX)
    else $error("back-EMF magnitude above the largest code value");
  chk_bemf_zero: assert property (bemf_code_mon == 7'h00 |=> bemf_linear == 11'h000)
    else $error("zero back-EMF code did not give zero");
  chk_zero_mant: assert property (res_code_mon[3:0] == 4'h0 |=> res_linear == 11'h000)
    else $error("zero mantissa did not give zero at some shift");
  chk_bemf_hold: assert property ($stable(bemf_code_mon) [*2] |-> $stable(bemf_linear))
    else $error("back-EMF magnitude moved with code held");

  // Only codes 0x01, 0x02 and 0x11 decode to a nonzero value below 3
  chk_flag_match: assert property (1'b1 |=>
      res_below_min == ($past(res_code_mon) inside {7'h01, 7'h02, 7'h11}))
    else $error("low resistance flag disagrees with code");

endmodule // mpd_top

/* File: rtl/mpd_pkg.sv */
package mpd_pkg;

  localparam int CODE_W = 7;
  localparam int EXP_W = 3;
  localparam int MANT_W = 4;
  localparam int LIN_W = 11;

  // Field positions inside a configuration code
  localparam int MANT_LSB = 0;
  localparam int EXP_LSB = 4;

  // Register byte offsets
  localparam logic [7:0] OFS_MOTOR_CFG_FIRST = 8'h00;
  localparam logic [7:0] OFS_MOTOR_CFG_SECOND = 8'h04;
  localparam logic [7:0] OFS_RES_LINEAR = 8'h08;
  localparam logic [7:0] OFS_BEMF_LINEAR = 8'h0c;
  localparam logic [7:0] OFS_SCALE = 8'h10;

  localparam logic [CODE_W-1:0] RST_CODE = 7'h00;
  localparam logic [LIN_W-1:0] RST_LINEAR = 11'h000;

  // Scaling of the decoded magnitudes
  localparam logic [15:0] RES_LSB_UOHM = 16'h25c6;
  localparam logic [15:0] BEMF_WEIGHT = 16'h0442;
  localparam logic [LIN_W-1:0] RES_LINEAR_MIN = 11'h003;
  localparam logic [LIN_W-1:0] LINEAR_MAX = 11'h780;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } mpd_req_t;

  typedef struct packed {
    logic [CODE_W-1:0] phase_res_code;
    logic [CODE_W-1:0] bemf_code;
  } mpd_cfg_t;

endpackage

/* File: rtl/mpd_code_expand.sv */
`timescale 1ns/100ps
module mpd_code_expand
  import mpd_pkg::*;
#(
  parameter int EW = EXP_W,
  parameter int MW = MANT_W,
  parameter int OW = LIN_W
) (
  input wire logic [EW+MW-1:0] code,
  output logic [OW-1:0] linear
);

  // The widest mantissa at the largest shift must fit without loss
  if (OW < MW + (1 << EW) - 1) begin : g_bad_width
    $error("mpd_code_expand: output too narrow for exponent range");
  end

  logic [EW-1:0] exponent;
  logic [MW-1:0] mantissa;

  always_comb begin
    exponent = code[EW+MW-1:MW];
    mantissa = code[MW-1:0];
    linear = OW'(mantissa) << exponent;
  end

endmodule // mpd_code_expand

/* File: testbench/mpd_tb.sv */
`timescale 1ns/100ps
module testbench
  import mpd_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [LIN_W-1:0] res_linear;
  logic [LIN_W-1:0] bemf_linear;
  logic res_below_min;
  int err_count = 0;
  int checks_done = 0;

  assign hready = hreadyout;
  always #4 hclk = ~hclk;

  mpd_top mpd_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .res_linear(res_linear),
    .bemf_linear(bemf_linear), .res_below_min(res_below_min));

  function automatic logic [10:0] dec(logic [6:0] c);
    dec = {7'h0, c[3:0]} << c[6:4];
  endfunction

  task automatic chk(string n, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", n, exp, got);
      err_count++;
    end
  endtask

  // Address phase held until hready, then data phase held until hready again
  task automatic xfer(logic wr, logic [7:0] a, logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] v;
    xfer(1'b1, a, d, v);
  endtask

  task automatic rd_chk(string n, logic [7:0] a, logic [31:0] exp);
    logic [31:0] v;
    xfer(1'b0, a, 32'h0, v);
    chk(n, exp, v);
  endtask

  task automatic out_chk(logic [10:0] r, logic [10:0] b);
    chk("res_linear", {21'h0, r}, {21'h0, res_linear});
    chk("bemf_linear", {21'h0, b}, {21'h0, bemf_linear});
    chk("res_below_min", {31'h0, r == 11'h1 || r == 11'h2}, {31'h0, res_below_min});
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    err_count++;
    report_and_stop();
  end

  initial begin
    logic [6:0] c;
    logic [10:0] e;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1;
    out_chk(11'h0, 11'h0);
    chk("hreadyout", 32'h1, {31'h0, hreadyout});
    rd_chk("cfg_first", OFS_MOTOR_CFG_FIRST, 32'h0);
    rd_chk("scale", OFS_SCALE, {16'h0442, 16'h25c6});
    rd_chk("unmapped", 8'hfc, 32'h0);
    $display("test reset done");
    // Upper data bits set to show that only the code field is kept
    for (int i = 0; i < 128; i++) begin
      c = i[6:0];
      e = dec(c);
      wr(OFS_MOTOR_CFG_FIRST, {25'h1ffffff, c});
      wr(OFS_MOTOR_CFG_SECOND, {25'h1ffffff, ~c});
      repeat (2) @(posedge hclk);
      #1;
      out_chk(e, dec(~c));
      rd_chk("res_reg", OFS_RES_LINEAR, {20'h0, e == 11'h1 || e == 11'h2, e});
      rd_chk("cfg_first", OFS_MOTOR_CFG_FIRST, {25'h0, c});
      rd_chk("bemf_reg", OFS_BEMF_LINEAR, {21'h0, dec(~c)});
    end
    $display("test all codes done");
    wr(OFS_MOTOR_CFG_SECOND, 32'h1);
    repeat (2) @(posedge hclk);
    #1;
    out_chk(11'd1920, 11'd1);
    wr(OFS_MOTOR_CFG_FIRST, 32'h0);
    wr(OFS_MOTOR_CFG_SECOND, 32'h7f);
    repeat (6) @(posedge hclk);
    #1;
    out_chk(11'h0, 11'd1920);
    wr(OFS_BEMF_LINEAR, 32'hffffffff);
    rd_chk("ro_bemf", OFS_BEMF_LINEAR, 32'd1920);
    wr(8'h14, 32'hffffffff);
    rd_chk("unmapped", 8'h14, 32'h0);
    $display("test limits done");
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    #1;
    out_chk(11'h0, 11'h0);
    @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk("cfg_second", OFS_MOTOR_CFG_SECOND, 32'h0);
    $display("test second reset done");
    report_and_stop();
  end
endmodule // testbench
